// ### hw/ssrc_start_ctrl.sv
`timescale 1ns/1ps
module ssrc_start_ctrl
    import ssrc_pkg::*;
#(
    parameter int unsigned AUTO_CYC  = AUTO_DLY_CYC,
    parameter int unsigned RESP_CYCS = RESP_CYC,
    parameter int unsigned MAN_CYC   = MAN_DLY_CYC,
    parameter int unsigned PULSE_CYC = MON_PULSE_CYC,
    parameter int unsigned MON_CYC   = MON_DLY_CYC,
    parameter int unsigned TW        = 28
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         supplyActive,
    input  wire ssrc_start_t  startIn,
    output logic              restartControlOutput,
    output logic              safetyOutputs,
    output ssrc_status_t      status
);
    ssrc_state_t  state_r;
    ssrc_state_t  state_nxt;
    ssrc_mode_t   mode_r;
    ssrc_mode_t   mode_nxt;
    logic         safeOut_r;
    logic         safeOut_nxt;
    logic         cfgErr_r;
    logic         cfgErr_nxt;
    logic         startPrev_r;
    logic         startPrev_nxt;
    logic         pulseOk_r;
    logic         pulseOk_nxt;
    logic         tLoad;
    logic [TW-1:0] tVal;
    logic         tDone;
    logic         pLoad;
    logic         pDone;
    logic         startNow;
    logic         fallEdge;
    ssrc_mode_t   wiredMode;
    logic         bothWired;

    // every check below runs on the one clock and pauses in reset
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // wiring decode
    // ----------------------------------------
    // mode decided from the channels alone; no other setting exists
    always_comb begin
        bothWired = startIn.autoManual && startIn.monitored;
        if (startIn.autoBridged) begin
            wiredMode = SSRC_MODE_AUTO;
        end else if (startIn.monitored) begin
            wiredMode = SSRC_MODE_MON;
        end else begin
            wiredMode = SSRC_MODE_MAN;
        end
    end

    // channel one view: auto mode sees a permanently active start
    assign startNow = (mode_r == SSRC_MODE_AUTO) ? 1'b1 :
                      startIn.autoManual;
    // channel two is watched in manual and monitored mode: while idle it reads the same
    // as an unwired channel, so its mode cannot be latched in advance
    assign fallEdge = startPrev_r && !startIn.monitored;

    // control output feeds the start channels while not in error
    assign restartControlOutput = (state_r != SSRC_ST_ERR);

    // ----------------------------------------
    // timers
    // ----------------------------------------
    // main delay timer: activation delays only; outputs drop without delay
    ssrc_timer #(.WIDTH(TW)) uDelay (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .load    (tLoad),
        .loadVal (tVal),
        .expired (tDone)
    );
    // pulse-width qualifier for monitored start
    ssrc_timer #(.WIDTH(TW)) uPulse (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .load    (pLoad),
        .loadVal (TW'(PULSE_CYC)),
        .expired (pDone)
    );
    assign pLoad = startIn.monitored && !startPrev_r;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // outputs drop the cycle after supply loss, well inside the limit
    always_comb begin
        state_nxt     = state_r;
        mode_nxt      = mode_r;
        safeOut_nxt   = 1'b0;
        cfgErr_nxt    = cfgErr_r;
        startPrev_nxt = startIn.monitored;
        pulseOk_nxt   = pulseOk_r;
        tLoad         = 1'b0;
        tVal          = TW'(MAN_CYC);
        // a fresh rise on channel two restarts the width check
        if (pLoad) begin
            pulseOk_nxt = 1'b0;
        end else if (startIn.monitored && pDone) begin
            pulseOk_nxt = 1'b1;
        end
        case (state_r)
            SSRC_ST_SAFE: begin
                mode_nxt = wiredMode;
                if (bothWired) begin
                    cfgErr_nxt = 1'b1;
                    state_nxt  = SSRC_ST_ERR;
                end else if (supplyActive) begin
                    state_nxt = SSRC_ST_ARM;
                end
            end
            SSRC_ST_ARM: begin
                // a wiring fault outranks supply loss so it is never lost
                if (bothWired) begin
                    cfgErr_nxt = 1'b1;
                    state_nxt  = SSRC_ST_ERR;
                end else if (!supplyActive) begin
                    state_nxt = SSRC_ST_SAFE;
                end else if (mode_r == SSRC_MODE_AUTO) begin
                    tLoad     = 1'b1;
                    tVal      = TW'(MAN_CYC);
                    state_nxt = SSRC_ST_WAIT;
                end else if (mode_r == SSRC_MODE_MAN && startNow) begin
                    tLoad     = 1'b1;
                    tVal      = TW'(MAN_CYC);
                    state_nxt = SSRC_ST_WAIT;
                end else if (fallEdge && pulseOk_r) begin
                    // activity on channel two is what marks monitored mode
                    mode_nxt  = SSRC_MODE_MON;
                    tLoad     = 1'b1;
                    tVal      = TW'(MON_CYC);
                    state_nxt = SSRC_ST_WAIT;
                end
            end
            SSRC_ST_WAIT: begin
                if (bothWired) begin
                    cfgErr_nxt = 1'b1;
                    state_nxt  = SSRC_ST_ERR;
                end else if (!supplyActive) begin
                    state_nxt = SSRC_ST_SAFE;
                end else if (tDone) begin
                    safeOut_nxt = 1'b1;
                    state_nxt   = SSRC_ST_RUN;
                end
            end
            SSRC_ST_RUN: begin
                safeOut_nxt = 1'b1;
                if (bothWired) begin
                    safeOut_nxt = 1'b0;
                    cfgErr_nxt  = 1'b1;
                    state_nxt   = SSRC_ST_ERR;
                end else if (!supplyActive) begin
                    safeOut_nxt = 1'b0;
                    state_nxt   = SSRC_ST_SAFE;
                end
            end
            SSRC_ST_ERR: begin
                state_nxt = SSRC_ST_ERR;
            end
            default: begin
                state_nxt = SSRC_ST_ERR;
            end
        endcase
    end

    // registers only; reset stands for power-on
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= SSRC_ST_SAFE;
            mode_r      <= SSRC_MODE_NONE;
            safeOut_r   <= 1'b0;
            cfgErr_r    <= 1'b0;
            startPrev_r <= 1'b0;
            pulseOk_r   <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            mode_r      <= mode_nxt;
            safeOut_r   <= safeOut_nxt;
            cfgErr_r    <= cfgErr_nxt;
            startPrev_r <= startPrev_nxt;
            pulseOk_r   <= pulseOk_nxt;
        end
    end

    assign safetyOutputs    = safeOut_r;
    assign status.outputsOn = safeOut_r;
    assign status.cfgError  = cfgErr_r;
    assign status.waiting   = (state_r == SSRC_ST_ARM);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_supply_drop: assert property (
        !supplyActive |=> !safetyOutputs)
        else $error("outputs still on after supply loss");
    chk_error_sticky: assert property (
        state_r == SSRC_ST_ERR |=> state_r == SSRC_ST_ERR && !safetyOutputs)
        else $error("error state left or outputs on");
    chk_both_wired: assert property (
        bothWired |=> !safetyOutputs && cfgErr_r)
        else $error("both channels wired but no error");
    chk_out_cause: assert property (
        $rose(safetyOutputs) |-> $past(state_r) == SSRC_ST_WAIT)
        else $error("outputs on without delay phase");
    chk_man_hold: assert property (
        state_r == SSRC_ST_ARM && mode_r == SSRC_MODE_MAN && !startNow
        && !fallEdge |=> state_r != SSRC_ST_WAIT)
        else $error("manual delay started without start");
    chk_mon_short: assert property (
        state_r == SSRC_ST_ARM && mode_r != SSRC_MODE_AUTO && fallEdge
        && !pulseOk_r && !startNow && supplyActive && !bothWired
        |=> state_r == SSRC_ST_ARM)
        else $error("short monitored pulse accepted");
    chk_wait_bound: assert property (
        state_r == SSRC_ST_WAIT && tDone && supplyActive && !bothWired
        |=> safetyOutputs)
        else $error("delay expired but outputs stay off");
    chk_auto_start: assert property (
        state_r == SSRC_ST_ARM && mode_r == SSRC_MODE_AUTO && supplyActive
        && !bothWired |=> state_r == SSRC_ST_WAIT)
        else $error("auto mode did not start");
endmodule // ssrc_start_ctrl

// ### hw/ssrc_pkg.sv
package ssrc_pkg;
    // base clock rate and derived units
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
    // timing figures in milliseconds
    localparam int unsigned AUTO_DLY_MS  = 1500;
    localparam int unsigned RESP_MS      = 150;
    localparam int unsigned MAN_DLY_MS   = 100;
    localparam int unsigned MON_PULSE_MS = 80;
    localparam int unsigned MON_DLY_MS   = 100;
    // derived cycle counts (exact whole multiples of CYC_PER_MS, no rounding)
    localparam int unsigned AUTO_DLY_CYC = AUTO_DLY_MS * CYC_PER_MS;
    localparam int unsigned RESP_CYC     = RESP_MS * CYC_PER_MS;
    localparam int unsigned MAN_DLY_CYC  = MAN_DLY_MS * CYC_PER_MS;
    localparam int unsigned MON_PULSE_CYC = MON_PULSE_MS * CYC_PER_MS;
    localparam int unsigned MON_DLY_CYC  = MON_DLY_MS * CYC_PER_MS;
    // wiring-selected start mode
    typedef enum logic [3:0] {
        SSRC_MODE_NONE = 4'h1,
        SSRC_MODE_AUTO = 4'h2,
        SSRC_MODE_MAN  = 4'h4,
        SSRC_MODE_MON  = 4'h8
    } ssrc_mode_t;
    // sequencer states, one-hot
    typedef enum logic [4:0] {
        SSRC_ST_SAFE  = 5'h01,
        SSRC_ST_ARM   = 5'h02,
        SSRC_ST_WAIT  = 5'h04,
        SSRC_ST_RUN   = 5'h08,
        SSRC_ST_ERR   = 5'h10
    } ssrc_state_t;
    // start-input channel group
    typedef struct packed {
        logic autoManual;
        logic monitored;
        logic autoBridged;
    } ssrc_start_t;
    // status group
    typedef struct packed {
        logic outputsOn;
        logic cfgError;
        logic waiting;
    } ssrc_status_t;
endpackage

// ### hw/ssrc_timer.sv
`timescale 1ns/1ps
// down-counting interval timer, loaded by a pulse, reports expiry as a level
module ssrc_timer #(
    parameter int unsigned WIDTH = 28
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadVal,
    output logic                  expired
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    // ----------------------------------------
    // count logic
    // ----------------------------------------
    // next count: load wins, otherwise step down to zero and hold
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = loadVal;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - WIDTH'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired = (cnt_r == '0) && !load;
endmodule // ssrc_timer

// ### tb/ssrc_far_side.sv
`timescale 1ns/1ps
// supply switch chain plus start button, strapped onto the start channels
module ssrc_far_side
    import ssrc_pkg::*;
#(
    parameter int unsigned WAIT_CYC = 20
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [1:0] wiring, // 0 none, 1 manual, 2 auto, 3 monitored
    input  wire logic       both,
    output logic            supplyActive,
    output ssrc_start_t     startIn
);
    int unsigned upCyc;
    logic        btn;
    initial begin
        supplyActive = 1'b0;
        btn = 1'b0;
    end
    // age since power-on, so the button can be held back
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) upCyc <= 0;
        else if (upCyc < WAIT_CYC) upCyc <= upCyc + 1;
    end
    // unwired channels read low; a bridged channel one reads high
    always_comb begin
        startIn.autoBridged = (wiring == 2'h2);
        startIn.autoManual  = (wiring == 2'h2) ||
                              ((wiring == 2'h1 || both) && btn);
        startIn.monitored   = (wiring == 2'h3 || both) && btn;
    end
    task automatic setSupply(input logic v);
        @(negedge mclk);
        supplyActive = v;
    endtask
    // a short len breaks the minimum pulse on purpose
    task automatic press(input int len);
        while (upCyc < WAIT_CYC) @(negedge mclk);
        @(negedge mclk);
        btn = 1'b1;
        repeat (len) @(negedge mclk);
        btn = 1'b0;
    endtask
endmodule // ssrc_far_side

// ### tb/ssrc_start_ctrl_tb.sv
`timescale 1ns/1ps
module ssrc_start_ctrl_tb;
    import ssrc_pkg::*;
    localparam int unsigned MANC = 10;
    localparam int unsigned MONC = 10;
    localparam int unsigned AUTOC = 20;
    localparam int unsigned PULSEC = 8;
    localparam int unsigned WAITC = 20;
    logic [1:0]   wiring = 2'h0;
    logic         bothCh = 1'b0;
    logic         mclk;
    logic         rst_n;
    logic         supplyActive;
    ssrc_start_t  startIn;
    logic         restartControlOutput;
    logic         safetyOutputs;
    ssrc_status_t status;
    int           err_count = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    ssrc_far_side #(.WAIT_CYC(WAITC)) u_ssrc_far_side (.mclk(mclk),
        .rst_n(rst_n), .wiring(wiring), .both(bothCh),
        .supplyActive(supplyActive), .startIn(startIn));
    ssrc_start_ctrl #(.AUTO_CYC(AUTOC), .MAN_CYC(MANC), .PULSE_CYC(PULSEC),
        .MON_CYC(MONC)) u_ssrc_start_ctrl (.mclk(mclk), .rst_n(rst_n),
        .supplyActive(supplyActive), .startIn(startIn),
        .restartControlOutput(restartControlOutput),
        .safetyOutputs(safetyOutputs), .status(status));
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // power cycle, which is the only way out of the error state
    task automatic powerCycle(input logic [1:0] w);
        @(negedge mclk);
        rst_n = 1'b0;
        wiring = w;
        bothCh = 1'b0;
        u_ssrc_far_side.setSupply(1'b0);
        repeat (3) @(negedge mclk);
        check("rstOut", safetyOutputs, 1'b0);
        check("rstStat", status, 3'h0);
        check("rstCtl", restartControlOutput, 1'b1);
        rst_n = 1'b1;
    endtask
    // bounded wait for the outputs, timed from cycle t0
    task automatic expectOn(input int t0, input int lim);
        while (safetyOutputs !== 1'b1 && cyc - t0 <= lim) @(negedge mclk);
        check("onInTime", cyc - t0 <= lim, 1'b1);
        check("outputsOn", status.outputsOn, 1'b1);
    endtask
    task automatic dropSupply();
        u_ssrc_far_side.setSupply(1'b0);
        @(negedge mclk);
        check("offAfterDrop", safetyOutputs, 1'b0);
    endtask
    task automatic testManual();
        int t0;
        powerCycle(2'h1);
        u_ssrc_far_side.setSupply(1'b1);
        repeat (30) @(negedge mclk);
        check("manHold", safetyOutputs, 1'b0);
        check("manWait", status.waiting, 1'b1);
        t0 = cyc;
        u_ssrc_far_side.press(3);
        expectOn(t0, MANC + 3);
        dropSupply();
    endtask
    task automatic testAuto();
        powerCycle(2'h2);
        u_ssrc_far_side.setSupply(1'b1);
        expectOn(cyc, MANC + 4);
        dropSupply();
    endtask
    task automatic testMonitored();
        powerCycle(2'h3);
        u_ssrc_far_side.setSupply(1'b1);
        u_ssrc_far_side.press(4);
        repeat (30) @(negedge mclk);
        check("shortPulse", safetyOutputs, 1'b0);
        u_ssrc_far_side.press(12);
        check("beforeFall", safetyOutputs, 1'b0);
        expectOn(cyc, MONC + 3);
        dropSupply();
    endtask
    task automatic testBothWired();
        powerCycle(2'h0);
        bothCh = 1'b1;
        u_ssrc_far_side.setSupply(1'b1);
        u_ssrc_far_side.press(12);
        repeat (3) @(negedge mclk);
        check("cfgErr", status.cfgError, 1'b1);
        check("errCtl", restartControlOutput, 1'b0);
        bothCh = 1'b0;
        wiring = 2'h1;
        u_ssrc_far_side.press(3);
        repeat (30) @(negedge mclk);
        check("errSticky", safetyOutputs, 1'b0);
        check("errHeld", status.cfgError, 1'b1);
        powerCycle(2'h1);
        @(negedge mclk);
        check("errCleared", status.cfgError, 1'b0);
    endtask
    // limit sits well above the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        testManual();
        testAuto();
        testMonitored();
        testBothWired();
        results();
    end
endmodule // ssrc_start_ctrl_tb
